// File: include/cslc_params.svh
// Constants for the chassis status indicator controller.
// Assumes a 40 MHz standby system clock.
`ifndef CSLC_PARAMS_SVH
`define CSLC_PARAMS_SVH
`define CSLC_CLK_HZ 40000000
`define CSLC_BLINK_HZ 1
`define CSLC_BLINK_HALF (`CSLC_CLK_HZ / (2 * `CSLC_BLINK_HZ))
`define CSLC_SLOTS 8
`define CSLC_DEBOUNCE_CYC 4
`endif

// File: include/cslc_pkg.sv
// Types for the chassis status indicator controller.
// Assumes nothing beyond the params header.
package cslc_pkg;
    typedef enum logic [2:0] {
        CSLC_SYS_OFF,
        CSLC_SYS_NORMAL,
        CSLC_SYS_DEGRADED,
        CSLC_SYS_NONCRIT,
        CSLC_SYS_CRITICAL
    } cslc_sys_e;
    typedef enum logic [2:0] {
        CSLC_PWR_LEGACY_OFF,
        CSLC_PWR_LEGACY_ON,
        CSLC_PWR_S0,
        CSLC_PWR_SLEEP,
        CSLC_PWR_S4,
        CSLC_PWR_S5
    } cslc_pwr_e;
endpackage

// File: hdl/cslc_blink.sv
// Shared free-running blink divider.
// Assumes one clock; toggles every HALF cycles for a 50% duty blink.
`include "cslc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module cslc_blink #(
    parameter int HALF = `CSLC_BLINK_HALF
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    output logic blink_out
);
    initial begin
        if (HALF < 1) begin
            $error("HALF must be at least one");
        end
    end
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_blink;
    always_comb begin
        next_count = count + 32'h1;
        next_blink = blink_out;
        if (count >= 32'(HALF - 1)) begin
            next_count = 32'h0;
            next_blink = ~blink_out;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count <= 32'h0;
            blink_out <= 1'b0;
        end else begin
            count <= next_count;
            blink_out <= next_blink;
        end
    end
endmodule
`default_nettype wire

// File: hdl/cslc_press.sv
// Button press detector: debounce by a short stable count, then one-cycle pulse.
// Assumes an active-low button already synchronous to the clock.
`include "cslc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module cslc_press #(
    parameter int STABLE = `CSLC_DEBOUNCE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic btn_n_in,
    output logic press_out
);
    initial begin
        if (STABLE < 1 || STABLE > 255) begin
            $error("STABLE out of range");
        end
    end
    logic [7:0] cnt;
    logic held;
    logic [7:0] next_cnt;
    logic next_held;
    logic next_press;
    always_comb begin
        next_cnt = cnt;
        next_held = held;
        next_press = 1'b0;
        if (btn_n_in == held) begin
            // Raw differs from the filtered level (held is active-high)
            if (cnt >= 8'(STABLE - 1)) begin
                next_cnt = 8'h0;
                next_held = ~held;
                next_press = ~held;
            end else begin
                next_cnt = cnt + 8'h1;
            end
        end else begin
            next_cnt = 8'h0;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt <= 8'h0;
            held <= 1'b0;
            press_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            held <= next_held;
            press_out <= next_press;
        end
    end
endmodule
`default_nettype wire

// File: hdl/cslc_top.sv
// Chassis front panel and drive backplane indicator logic.
// Assumes standby-powered clock and reset; all inputs synchronous to sys_clk_in.
// LED outputs are active-high "lit" levels; pad drivers handle polarity.
`include "cslc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module cslc_top #(
    parameter int SLOTS = `CSLC_SLOTS,
    parameter int BLINK_HALF = `CSLC_BLINK_HALF,
    parameter int DEBOUNCE = `CSLC_DEBOUNCE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [SLOTS-1:0] encl_act_in,
    input wire logic [SLOTS-1:0] drive_act_in,
    input wire logic [SLOTS-1:0] drive_err_in,
    input wire logic [SLOTS-1:0] drive_rebuild_in,
    input wire logic remote_id_set_in,
    input wire logic remote_id_clr_in,
    input wire logic id_btn_n_in,
    input wire logic nmi_btn_n_in,
    input wire logic pwr_btn_n_in,
    input wire cslc_pkg::cslc_sys_e sys_state_in,
    input wire cslc_pkg::cslc_pwr_e pwr_state_in,
    input wire logic main_pwr_good_in,
    input wire logic fw_sleep_clr_in,
    input wire logic acpi_sleep_en_in,
    output logic [SLOTS-1:0] act_led_out,
    output logic [SLOTS-1:0] fault_led_out,
    output logic id_led_out,
    output logic board_id_led_out,
    output logic stat_green_out,
    output logic stat_amber_out,
    output logic pwr_led_out,
    output logic pwr_toggle_out,
    output logic sleep_req_out,
    output logic nmi_out,
    output logic halt_out
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    initial begin
        if (SLOTS != `CSLC_SLOTS) begin
            $error("SLOTS must equal the number of drive bays");
        end
    end

    // ------------------------------------------------------------
    // Shared blink and button detectors
    // ------------------------------------------------------------
    logic blink;
    logic id_press;
    logic nmi_press;
    logic pwr_press;

    // One divider for every blinking element keeps them in phase
    cslc_blink #(.HALF(BLINK_HALF)) u_blink (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .blink_out(blink)
    );
    cslc_press #(.STABLE(DEBOUNCE)) u_id_btn (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .btn_n_in(id_btn_n_in),
        .press_out(id_press)
    );
    cslc_press #(.STABLE(DEBOUNCE)) u_nmi_btn (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .btn_n_in(nmi_btn_n_in),
        .press_out(nmi_press)
    );
    cslc_press #(.STABLE(DEBOUNCE)) u_pwr_btn (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .btn_n_in(pwr_btn_n_in),
        .press_out(pwr_press)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic id_active;
    logic sleep_held;
    logic next_id_active;
    logic next_sleep_held;
    logic [SLOTS-1:0] next_act;
    logic [SLOTS-1:0] next_fault;
    logic next_id_led;
    logic next_green;
    logic next_amber;
    logic next_pwr;
    logic next_toggle;
    logic next_sleep_req;
    logic next_nmi;
    logic next_halt;

    always_comb begin
        // Drive slot indicators
        next_act = encl_act_in | drive_act_in;
        next_fault = drive_err_in | (drive_rebuild_in & {SLOTS{blink}});

        // Button toggles; a remote set or clear in the press cycle wins
        next_id_active = id_active ^ id_press;
        if (remote_id_set_in) begin
            next_id_active = 1'b1;
        end else if (remote_id_clr_in) begin
            next_id_active = 1'b0;
        end
        // Front and board identify share one source so they cannot drift apart
        next_id_led = id_active & blink;

        // Amber has priority; green goes dark whenever amber is requested
        next_green = 1'b0;
        next_amber = 1'b0;
        case (sys_state_in)
            cslc_pkg::CSLC_SYS_NORMAL: next_green = 1'b1;
            cslc_pkg::CSLC_SYS_DEGRADED: next_green = blink;
            cslc_pkg::CSLC_SYS_CRITICAL: next_amber = 1'b1;
            cslc_pkg::CSLC_SYS_NONCRIT: next_amber = blink;
            default: next_amber = 1'b0;
        endcase

        // Sleep indication survives main power loss; only firmware or a return to S0 clears it
        next_sleep_held = sleep_held;
        if (pwr_state_in == cslc_pkg::CSLC_PWR_SLEEP) begin
            next_sleep_held = 1'b1;
        end else if (fw_sleep_clr_in || pwr_state_in == cslc_pkg::CSLC_PWR_S0) begin
            next_sleep_held = 1'b0;
        end

        case (pwr_state_in)
            cslc_pkg::CSLC_PWR_S0: next_pwr = 1'b1;
            cslc_pkg::CSLC_PWR_LEGACY_ON: next_pwr = sleep_held ? blink : 1'b1;
            cslc_pkg::CSLC_PWR_SLEEP: next_pwr = main_pwr_good_in & blink;
            cslc_pkg::CSLC_PWR_S4: next_pwr = 1'b0;
            cslc_pkg::CSLC_PWR_S5: next_pwr = 1'b0;
            default: next_pwr = 1'b0;
        endcase

        // Power button: sleep request only when the OS enabled it
        next_toggle = pwr_press & ~acpi_sleep_en_in;
        next_sleep_req = pwr_press & acpi_sleep_en_in;

        // NMI pulses once; halt stays until reset since a dump follows
        next_nmi = nmi_press;
        next_halt = halt_out | nmi_press;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            id_active <= 1'b0;
            sleep_held <= 1'b0;
            act_led_out <= '0;
            fault_led_out <= '0;
            id_led_out <= 1'b0;
            board_id_led_out <= 1'b0;
            stat_green_out <= 1'b0;
            stat_amber_out <= 1'b0;
            pwr_led_out <= 1'b0;
            pwr_toggle_out <= 1'b0;
            sleep_req_out <= 1'b0;
            nmi_out <= 1'b0;
            halt_out <= 1'b0;
        end else begin
            id_active <= next_id_active;
            sleep_held <= next_sleep_held;
            act_led_out <= next_act;
            fault_led_out <= next_fault;
            id_led_out <= next_id_led;
            board_id_led_out <= next_id_led;
            stat_green_out <= next_green;
            stat_amber_out <= next_amber;
            pwr_led_out <= next_pwr;
            pwr_toggle_out <= next_toggle;
            sleep_req_out <= next_sleep_req;
            nmi_out <= next_nmi;
            halt_out <= next_halt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_act_follow;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (encl_act_in[0] | drive_act_in[0]) |=> act_led_out[0];
    endproperty
    a_act_follow: assert property (p_act_follow) else $error("activity led not lit");

    property p_err_steady;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        drive_err_in[0] |=> fault_led_out[0];
    endproperty
    a_err_steady: assert property (p_err_steady) else $error("fault led not steady");

    property p_id_dark;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !id_active |=> !id_led_out;
    endproperty
    a_id_dark: assert property (p_id_dark) else $error("identify led lit while idle");

    property p_id_toggle;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (id_press && !remote_id_set_in && !remote_id_clr_in) |=> (id_active != $past(id_active));
    endproperty
    a_id_toggle: assert property (p_id_toggle) else $error("identify did not toggle");

    property p_id_pair;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        id_led_out == board_id_led_out;
    endproperty
    a_id_pair: assert property (p_id_pair) else $error("identify leds differ");

    property p_amber_prio;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        stat_amber_out |-> !stat_green_out;
    endproperty
    a_amber_prio: assert property (p_amber_prio) else $error("green lit with amber");

    property p_normal_green;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (sys_state_in == cslc_pkg::CSLC_SYS_NORMAL) |=> (stat_green_out && !stat_amber_out);
    endproperty
    a_normal_green: assert property (p_normal_green) else $error("normal not green");

    property p_s0_on;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (pwr_state_in == cslc_pkg::CSLC_PWR_S0) |=> pwr_led_out;
    endproperty
    a_s0_on: assert property (p_s0_on) else $error("power led dark in S0");

    property p_s5_off;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (pwr_state_in == cslc_pkg::CSLC_PWR_S5 || pwr_state_in == cslc_pkg::CSLC_PWR_S4)
            |=> !pwr_led_out;
    endproperty
    a_s5_off: assert property (p_s5_off) else $error("power led lit in S4/S5");

    property p_sleep_req;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (pwr_press && acpi_sleep_en_in) |=> (sleep_req_out && !pwr_toggle_out);
    endproperty
    a_sleep_req: assert property (p_sleep_req) else $error("sleep request missing");

    property p_nmi_halt;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        nmi_press |=> (nmi_out && halt_out) ##1 (!nmi_out && halt_out);
    endproperty
    a_nmi_halt: assert property (p_nmi_halt) else $error("nmi or halt wrong");

    c_id_on: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) id_press ##1 id_active);
    c_rebuild: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        drive_rebuild_in[0] ##1 fault_led_out[0]);
    c_nmi: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) nmi_out);
    c_sleep_blink: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (pwr_state_in == cslc_pkg::CSLC_PWR_SLEEP) && pwr_led_out);
endmodule
`default_nettype wire

// File: bench/cslc_far_model.sv
// Far-side model: front panel buttons plus the listeners for the request pulses.
// Assumes sys_clk_in is the design clock; buttons have pull-ups and read high when released.
`timescale 1ns/10ps
`default_nettype none
module cslc_far_model #(
    parameter int HOLD = 12
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [2:0] press_req_in,
    input wire logic pwr_toggle_in,
    input wire logic sleep_req_in,
    input wire logic nmi_in,
    output logic [2:0] btn_n_out,
    output int toggle_cnt_out,
    output int sleep_cnt_out,
    output int nmi_cnt_out
);
    int hold [3];
    // Held well past the debounce so one press must give exactly one pulse
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold <= '{0, 0, 0};
            btn_n_out <= 3'h7;
            toggle_cnt_out <= 0;
            sleep_cnt_out <= 0;
            nmi_cnt_out <= 0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (press_req_in[i]) begin
                    hold[i] <= HOLD;
                end else if (hold[i] > 0) begin
                    hold[i] <= hold[i] - 1;
                end
                btn_n_out[i] <= !(press_req_in[i] || hold[i] > 1);
            end
            // High cycles are counted, so a stretched pulse shows as extra
            if (pwr_toggle_in === 1'b1) toggle_cnt_out <= toggle_cnt_out + 1;
            if (sleep_req_in === 1'b1) sleep_cnt_out <= sleep_cnt_out + 1;
            if (nmi_in === 1'b1) nmi_cnt_out <= nmi_cnt_out + 1;
        end
    end
endmodule
`default_nettype wire

// File: bench/tb_chassis_status_led_control.sv
// Self-checking bench for the chassis status indicator controller.
// Assumes a short blink half period (4) so 16 sampled cycles hold exactly 8 lit.
`timescale 1ns/10ps
`default_nettype none
module tb_chassis_status_led_control;
    logic sys_clk_in = 0, rstn_in = 0, remote_id_set_in = 0, remote_id_clr_in = 0;
    logic main_pwr_good_in = 1, fw_sleep_clr_in = 0, acpi_sleep_en_in = 0;
    logic [7:0] encl_act_in = 0, drive_act_in = 0, drive_err_in = 0, drive_rebuild_in = 0;
    logic [7:0] act_led_out, fault_led_out;
    logic id_led_out, board_id_led_out, stat_green_out, stat_amber_out, pwr_led_out;
    logic pwr_toggle_out, sleep_req_out, nmi_out, halt_out;
    logic [2:0] press_req = 0, btn_n;
    cslc_pkg::cslc_sys_e sys_state_in = cslc_pkg::CSLC_SYS_OFF;
    cslc_pkg::cslc_pwr_e pwr_state_in = cslc_pkg::CSLC_PWR_LEGACY_OFF;
    int toggle_cnt, sleep_cnt, nmi_cnt, bad_count = 0, comparisons = 0;
    int c_g, c_a, c_p, c_id, c_idm, c_f0, c_f1, c_ph, c_x;
    always #12.5 sys_clk_in = ~sys_clk_in;
    cslc_top #(.SLOTS(8), .BLINK_HALF(4), .DEBOUNCE(4)) uut (.sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in), .encl_act_in(encl_act_in), .drive_act_in(drive_act_in),
        .drive_err_in(drive_err_in), .drive_rebuild_in(drive_rebuild_in),
        .remote_id_set_in(remote_id_set_in), .remote_id_clr_in(remote_id_clr_in),
        .id_btn_n_in(btn_n[0]), .nmi_btn_n_in(btn_n[1]), .pwr_btn_n_in(btn_n[2]),
        .sys_state_in(sys_state_in), .pwr_state_in(pwr_state_in),
        .main_pwr_good_in(main_pwr_good_in), .fw_sleep_clr_in(fw_sleep_clr_in),
        .acpi_sleep_en_in(acpi_sleep_en_in), .act_led_out(act_led_out),
        .fault_led_out(fault_led_out), .id_led_out(id_led_out),
        .board_id_led_out(board_id_led_out), .stat_green_out(stat_green_out),
        .stat_amber_out(stat_amber_out), .pwr_led_out(pwr_led_out),
        .pwr_toggle_out(pwr_toggle_out), .sleep_req_out(sleep_req_out),
        .nmi_out(nmi_out), .halt_out(halt_out));
    cslc_far_model #(.HOLD(12)) far (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .press_req_in(press_req), .pwr_toggle_in(pwr_toggle_out),
        .sleep_req_in(sleep_req_out), .nmi_in(nmi_out), .btn_n_out(btn_n),
        .toggle_cnt_out(toggle_cnt), .sleep_cnt_out(sleep_cnt), .nmi_cnt_out(nmi_cnt));
    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            bad_count++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    // Lets the one-cycle output lag pass, then counts lit cycles over 16 edges
    task automatic watch();
        repeat (3) @(posedge sys_clk_in);
        {c_g, c_a, c_p, c_id, c_idm, c_f0, c_f1, c_ph, c_x} = '0;
        repeat (16) begin
            @(posedge sys_clk_in);
            #1;
            c_g += (stat_green_out === 1'b1);
            c_a += (stat_amber_out === 1'b1);
            c_p += (pwr_led_out === 1'b1);
            c_id += (id_led_out === 1'b1);
            c_idm += (id_led_out !== board_id_led_out);
            c_f0 += (fault_led_out[0] === 1'b1);
            c_f1 += (fault_led_out[1] === 1'b1);
            // Rebuild on slot 1 stays set, so its blink is the phase reference
            c_ph += (id_led_out !== fault_led_out[1]);
            // An unknown level would otherwise count as dark and pass
            c_x += $isunknown({stat_green_out, stat_amber_out, pwr_led_out, id_led_out,
                board_id_led_out, fault_led_out});
        end
        check(c_x == 0, "unknown indicator level");
        #1;
    endtask
    task automatic press(input int b);
        @(posedge sys_clk_in);
        #2 press_req[b] = 1;
        @(posedge sys_clk_in);
        #2 press_req[b] = 0;
        repeat (30) @(posedge sys_clk_in);
        #2;
    endtask
    task automatic t_drives();
        encl_act_in = 8'h05;
        drive_act_in = 8'h30;
        drive_err_in = 8'h81;
        drive_rebuild_in = 8'h42;
        watch();
        check(act_led_out === 8'h35, "activity leds");
        check(c_f0 == 16 && c_f1 == 8, "fault steady or blink");
        check((fault_led_out & 8'h3c) === 8'h00, "idle fault leds");
    endtask
    task automatic t_status();
        cslc_pkg::cslc_sys_e st [5] = '{cslc_pkg::CSLC_SYS_OFF, cslc_pkg::CSLC_SYS_NORMAL,
            cslc_pkg::CSLC_SYS_DEGRADED, cslc_pkg::CSLC_SYS_NONCRIT, cslc_pkg::CSLC_SYS_CRITICAL};
        int eg [5] = '{0, 16, 8, 0, 0};
        int ea [5] = '{0, 0, 0, 8, 16};
        for (int i = 0; i < 5; i++) begin
            sys_state_in = st[i];
            watch();
            check(c_g == eg[i] && c_a == ea[i], "status led");
        end
    endtask
    task automatic t_power();
        cslc_pkg::cslc_pwr_e ps [10] = '{cslc_pkg::CSLC_PWR_LEGACY_ON,
            cslc_pkg::CSLC_PWR_SLEEP, cslc_pkg::CSLC_PWR_SLEEP, cslc_pkg::CSLC_PWR_LEGACY_ON,
            cslc_pkg::CSLC_PWR_LEGACY_ON, cslc_pkg::CSLC_PWR_LEGACY_ON, cslc_pkg::CSLC_PWR_S0,
            cslc_pkg::CSLC_PWR_S4, cslc_pkg::CSLC_PWR_S5, cslc_pkg::CSLC_PWR_LEGACY_OFF};
        bit pg [10] = '{1, 0, 1, 1, 1, 1, 1, 1, 1, 1};
        bit fc [10] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 0};
        int ep [10] = '{16, 0, 8, 8, 16, 16, 16, 0, 0, 0};
        for (int i = 0; i < 10; i++) begin
            pwr_state_in = ps[i];
            main_pwr_good_in = pg[i];
            fw_sleep_clr_in = fc[i];
            watch();
            check(c_p == ep[i], "power led");
        end
    endtask
    task automatic t_ident();
        press(0);
        watch();
        check(c_id == 8 && c_idm == 0 && c_ph == 0, "identify on by button");
        press(0);
        watch();
        check(c_id == 0 && c_idm == 0, "identify off by button");
        remote_id_set_in = 1;
        @(posedge sys_clk_in);
        #2 remote_id_set_in = 0;
        watch();
        check(c_id == 8 && c_idm == 0 && c_ph == 0, "identify on remotely");
        remote_id_clr_in = 1;
        @(posedge sys_clk_in);
        #2 remote_id_clr_in = 0;
        watch();
        check(c_id == 0, "identify off remotely");
    endtask
    task automatic t_buttons();
        press(2);
        check(toggle_cnt == 1 && sleep_cnt == 0, "power toggle");
        acpi_sleep_en_in = 1;
        press(2);
        check(toggle_cnt == 1 && sleep_cnt == 1, "sleep request");
        check(halt_out === 1'b0 && nmi_cnt == 0, "no halt yet");
        press(1);
        check(nmi_cnt == 1 && halt_out === 1'b1, "nmi and halt");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_in);
        #2 rstn_in = 1;
        @(posedge sys_clk_in);
        #2;
        check({act_led_out, fault_led_out, id_led_out, board_id_led_out, stat_green_out,
            stat_amber_out, pwr_led_out, pwr_toggle_out, sleep_req_out, nmi_out,
            halt_out} === '0, "reset outputs");
        t_drives();
        t_status();
        t_power();
        t_ident();
        t_buttons();
        stop_test();
    end
    initial begin
        #(25 * 20000);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
